// file: core/oac_core.sv
`include "oac_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module oac_core (
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire logic              clkEn,
	input  wire logic              stepIn,
	input  wire logic [7:0]        dataIn,
	output logic      [7:0]        dataOut,
	output logic                   busy,
	output logic                   halt,
	output logic                   trap,
	output oac_pkg::oacSpiOut_type spiOut,
	input  wire logic              spiMiso
);

	oac_pkg::oacRegs_type   r;
	oac_pkg::oacRegs_type   n;
	oac_pkg::oacMemReq_type req;
	oac_pkg::oacAlu_type    aluRes;
	logic [1:0]             rstPipe;
	logic                   rstN;
	logic                   launch;
	logic [1:0]             len;
	logic [15:0]            pcn;
	logic [15:0]            ea;
	logic [15:0]            val;
	logic [7:0]             txNext;
	logic                   condFlag;

	// Instruction length from the first byte
	function automatic logic [1:0] instLen(input logic [7:0] op);
		if (op == `OAC_OP_CALLW || op == `OAC_OP_LDW)
			return 2'h3;
		else if (op[7])
			return 2'h2;
		else
			return 2'h1;
	endfunction

	// Negative and zero from a result
	function automatic logic [7:0] setNZ(input logic [7:0] f,
	                                     input logic [15:0] v);
		logic [7:0] o;
		o = f;
		o[`OAC_FLAG_NEG]  = v[15];
		o[`OAC_FLAG_ZERO] = (v == 16'h0000);
		return o;
	endfunction

	// Build a memory request
	function automatic oac_pkg::oacMemReq_type mkReq(input logic wr,
	                                                 input logic [1:0] nb,
	                                                 input logic [15:0] a,
	                                                 input logic [15:0] wd);
		oac_pkg::oacMemReq_type q;
		q.write  = wr;
		q.nBytes = nb;
		q.addr   = a;
		q.wdata  = wd;
		return q;
	endfunction

	// Byte sent in each slot of a transfer, data little endian
	function automatic logic [7:0] txByte(input logic [2:0] idx,
	                                      input oac_pkg::oacMemReq_type q);
		case (idx)
			3'h0:    return q.write ? `OAC_CMD_WRITE : `OAC_CMD_READ;
			3'h1:    return q.addr[15:8];
			3'h2:    return q.addr[7:0];
			3'h3:    return q.wdata[7:0];
			default: return q.wdata[15:8];
		endcase
	endfunction

	// Two-byte ALU forms
	function automatic oac_pkg::oacAlu_type alu(input logic [7:0] op,
	                                            input logic [15:0] a,
	                                            input logic [7:0] f,
	                                            input logic [15:0] v,
	                                            input logic lohi);
		oac_pkg::oacAlu_type o;
		logic [16:0]         sum;
		logic [31:0]         wide;
		o.acc = a;
		o.flags = f;
		sum = 17'h00000;
		wide = 32'h00000000;
		case (op[5:3])
			3'h0: o.acc = v;
			3'h1, 3'h3: begin
				if (op[4])
					sum = {1'b0, a} - {1'b0, v};
				else
					sum = {1'b0, a} + {1'b0, v};
				o.acc = sum[15:0];
				o.flags[`OAC_FLAG_CARRY] = sum[16];
				o.flags = setNZ(o.flags, o.acc);
			end
			3'h4, 3'h5, 3'h6: begin
				if (op[5:3] == 3'h4)
					o.acc = a & v;
				else if (op[5:3] == 3'h5)
					o.acc = a | v;
				else
					o.acc = a ^ v;
				o.flags = setNZ(o.flags, o.acc);
			end
			3'h7: begin
				// Low selector shifts left, high shifts right
				if (lohi) begin
					wide = {a, 16'h0000} >> v[3:0];
					o.acc = wide[31:16];
					o.flags[`OAC_FLAG_CARRY] = (v[3:0] != 4'h0) & wide[15];
				end else begin
					wide = {16'h0000, a} << v[3:0];
					o.acc = wide[15:0];
					o.flags[`OAC_FLAG_CARRY] = wide[16];
				end
				o.flags = setNZ(o.flags, o.acc);
			end
			default: o.acc = a;
		endcase
		return o;
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rstPipe <= 2'h0;
		else if (clkEn)
			rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstN = rstPipe[1];

	// Next-state logic: synchronisers, serial engine, sequencer
	always_comb begin
		n = r;
		launch = 1'b0;
		req = '0;
		aluRes = '0;
		len = instLen(r.op);
		pcn = r.pc + {14'h0000, len};
		ea = 16'h0000;
		val = 16'h0000;
		txNext = 8'h00;
		condFlag = 1'b0;
		n.stepS1 = stepIn;
		n.stepS2 = r.stepS1;
		n.inS1 = dataIn;
		n.inS2 = r.inS1;
		n.misoS1 = spiMiso;
		n.misoS2 = r.misoS1;
		n.memDone = 1'b0;

		// Done follows deselect by a cycle, so select gaps last at least two cycles
		if (r.spiAct && !r.csActive) begin
			n.spiAct = 1'b0;
			n.memDone = 1'b1;
		// Serial clock divider, sample on rise, shift out on fall
		end else if (r.spiAct) begin
			n.divCnt = r.divCnt + 3'h1;
			if (r.divCnt == `OAC_SPI_HALF_LAST) begin
				n.divCnt = 3'h0;
				n.sck = ~r.sck;
				if (!r.sck) begin
					n.shift = {r.shift[6:0], r.misoS2};
				end else if (r.bitIdx == 3'h7) begin
					if (r.byteIdx == 3'h3)
						n.rdata[7:0] = r.shift;
					else if (r.byteIdx == 3'h4)
						n.rdata[15:8] = r.shift;
					if (r.byteIdx == 3'h2 + {1'b0, r.memReq.nBytes}) begin
						n.csActive = 1'b0;
						n.mosi = 1'b0;
					end else begin
						txNext = txByte(r.byteIdx + 3'h1, r.memReq);
						n.byteIdx = r.byteIdx + 3'h1;
						n.bitIdx = 3'h0;
						n.shift = txNext;
						n.mosi = txNext[7];
					end
				end else begin
					n.bitIdx = r.bitIdx + 3'h1;
					n.mosi = r.shift[7];
				end
			end
		end

		case (r.state)
			oac_pkg::S_IDLE: begin
				// Start only on step, never while halted
				if (r.stepS2 && !r.halt) begin
					n.recovering = r.trap;
					n.trap = 1'b0;
					req = mkReq(1'b0, 2'h1, r.pc, 16'h0000);
					launch = 1'b1;
					n.state = oac_pkg::S_FETCH;
				end
			end
			oac_pkg::S_FETCH: begin
				if (r.memDone) begin
					n.op = r.rdata[7:0];
					if (instLen(r.rdata[7:0]) == 2'h1) begin
						n.state = oac_pkg::S_EXEC;
					end else begin
						req = mkReq(1'b0, instLen(r.rdata[7:0]) - 2'h1,
						            r.pc + 16'h0001, 16'h0000);
						launch = 1'b1;
						n.state = oac_pkg::S_OPND;
					end
				end
			end
			oac_pkg::S_OPND: begin
				if (r.memDone) begin
					n.opnd = r.rdata;
					n.state = oac_pkg::S_EXEC;
				end
			end
			oac_pkg::S_EXEC: begin
				n.state = oac_pkg::S_IDLE;
				n.pc = pcn;
				if (r.skip) begin
					n.skip = 1'b0;
				end else begin
					casez (r.op)
						`OAC_OP_NOP: n.pc = pcn;
						`OAC_OP_HALT: n.halt = 1'b1;
						`OAC_OP_TRAP: begin
							n.trap = 1'b1;
							n.halt = r.recovering;
						end
						`OAC_OP_DROP: n.sp = r.sp + `OAC_WORD_STEP;
						`OAC_OP_PUSH: begin
							n.sp = r.sp - `OAC_WORD_STEP;
							req = mkReq(1'b1, 2'h2, r.sp - `OAC_WORD_STEP, r.acc);
							launch = 1'b1;
							n.state = oac_pkg::S_MEMWR;
						end
						`OAC_OP_POP, `OAC_OP_RET: begin
							n.sp = r.sp + `OAC_WORD_STEP;
							n.dest = r.op[1] ? oac_pkg::DEST_PC : oac_pkg::DEST_ACC;
							req = mkReq(1'b0, 2'h2, r.sp, 16'h0000);
							launch = 1'b1;
							n.state = oac_pkg::S_MEMRD;
						end
						`OAC_OP_NOT: begin
							n.acc = ~r.acc;
							n.flags = setNZ(r.flags, ~r.acc);
							n.flags[`OAC_FLAG_ELSE] = 1'b1;
						end
						`OAC_OP_OUTLO: n.dataOut = r.acc[7:0];
						`OAC_OP_OUTHI: n.dataOut = r.acc[15:8];
						`OAC_OP_SETPTR: n.dp = r.acc;
						`OAC_OP_TEST: n.flags = setNZ(r.flags, r.acc);
						`OAC_OP_BRIND: n.pc = pcn + r.acc;
						`OAC_OP_STATUS: n.acc = {8'h00, r.flags};
						`OAC_OP_LDIND: begin
							n.dest = oac_pkg::DEST_ACC;
							req = mkReq(1'b0, 2'h2, r.acc & `OAC_ALIGN_MASK, 16'h0000);
							launch = 1'b1;
							n.state = oac_pkg::S_MEMRD;
						end
						`OAC_OP_LDW: n.acc = r.opnd;
						`OAC_OP_CALLIND, `OAC_OP_CALLW, `OAC_OP_CALL: begin
							// Jump taken as the return address push is launched
							if (r.op == `OAC_OP_CALLIND)
								n.pc = r.acc;
							else if (r.op == `OAC_OP_CALLW)
								n.pc = r.opnd;
							else
								n.pc = {5'h00, r.op[2:0], r.opnd[7:0]};
							n.sp = r.sp - `OAC_WORD_STEP;
							req = mkReq(1'b1, 2'h2, r.sp - `OAC_WORD_STEP, pcn);
							launch = 1'b1;
							n.state = oac_pkg::S_MEMWR;
						end
						`OAC_OP_BRANCH:
							n.pc = pcn + {{5{r.op[2]}}, r.op[2:0], r.opnd[7:0]};
						`OAC_OP_IF: begin
							case (r.opnd[2:1])
								2'h0:    condFlag = r.flags[`OAC_FLAG_ZERO];
								2'h1:    condFlag = r.flags[`OAC_FLAG_ELSE];
								2'h2:    condFlag = r.flags[`OAC_FLAG_NEG];
								default: condFlag = r.flags[`OAC_FLAG_CARRY];
							endcase
							if (r.opnd[7:3] != 5'h00) begin
								n.trap = 1'b1;
								n.halt = r.recovering;
							end else if (condFlag == r.opnd[0]) begin
								n.skip = 1'b1;
								req = mkReq(1'b0, 2'h1, pcn, 16'h0000);
								launch = 1'b1;
								n.state = oac_pkg::S_FETCH;
							end
						end
						`OAC_OP_SRC: begin
							if (!r.op[2]) begin
								// Constants and inputs fill one byte only
								if (r.op[1])
									val = r.op[0] ? {r.inS2, 8'h00} : {8'h00, r.inS2};
								else
									val = r.op[0] ? {r.opnd[7:0], 8'h00} : {8'h00, r.opnd[7:0]};
								if (r.op[7:3] == `OAC_ALU_STORE) begin
									n.trap = 1'b1;
									n.halt = r.recovering;
								end else begin
									aluRes = alu(r.op, r.acc, r.flags, val, r.op[0]);
									n.acc = aluRes.acc;
									n.flags = aluRes.flags;
								end
							end else begin
								ea = (r.op[1] ? r.sp : r.dp) + {8'h00, r.opnd[7:0]};
								n.lohi = ea[0];
								n.dest = oac_pkg::DEST_ALU;
								launch = 1'b1;
								if (r.op[0]) begin
									req = mkReq(1'b0, 2'h2, ea & `OAC_ALIGN_MASK, 16'h0000);
									n.state = oac_pkg::S_PTR;
								end else if (r.op[7:3] == `OAC_ALU_STORE) begin
									req = mkReq(1'b1, 2'h2, ea & `OAC_ALIGN_MASK, r.acc);
									n.state = oac_pkg::S_MEMWR;
								end else begin
									req = mkReq(1'b0, 2'h2, ea & `OAC_ALIGN_MASK, 16'h0000);
									n.state = oac_pkg::S_MEMRD;
								end
							end
						end
						default: begin
							n.trap = 1'b1;
							n.halt = r.recovering;
						end
					endcase
				end
			end
			oac_pkg::S_PTR: begin
				if (r.memDone) begin
					n.lohi = r.rdata[0];
					launch = 1'b1;
					if (r.op[7:3] == `OAC_ALU_STORE) begin
						req = mkReq(1'b1, 2'h2, r.rdata & `OAC_ALIGN_MASK, r.acc);
						n.state = oac_pkg::S_MEMWR;
					end else begin
						req = mkReq(1'b0, 2'h2, r.rdata & `OAC_ALIGN_MASK, 16'h0000);
						n.state = oac_pkg::S_MEMRD;
					end
				end
			end
			oac_pkg::S_MEMRD: begin
				if (r.memDone) begin
					n.state = oac_pkg::S_IDLE;
					case (r.dest)
						oac_pkg::DEST_ACC: n.acc = r.rdata;
						oac_pkg::DEST_PC:  n.pc = r.rdata;
						default: begin
							aluRes = alu(r.op, r.acc, r.flags, r.rdata, r.lohi);
							n.acc = aluRes.acc;
							n.flags = aluRes.flags;
						end
					endcase
				end
			end
			oac_pkg::S_MEMWR: begin
				if (r.memDone)
					n.state = oac_pkg::S_IDLE;
			end
			default: n.state = oac_pkg::S_IDLE;
		endcase

		// Open a new transfer: select low, first command bit out
		if (launch) begin
			txNext = txByte(3'h0, req);
			n.memReq = req;
			n.spiAct = 1'b1;
			n.csActive = 1'b1;
			n.sck = 1'b0;
			n.divCnt = 3'h0;
			n.bitIdx = 3'h0;
			n.byteIdx = 3'h0;
			n.shift = txNext;
			n.mosi = txNext[7];
			n.rdata = 16'h0000;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			r <= '0;
		end else if (clkEn) begin
			r <= n;
		end
	end

	// Outputs
	assign dataOut = r.dataOut;
	assign busy = (r.state != oac_pkg::S_IDLE);
	assign halt = r.halt;
	assign trap = r.trap;
	assign spiOut.csN = ~r.csActive;
	assign spiOut.sck = r.sck;
	assign spiOut.mosi = r.mosi;

endmodule // oac_core

`default_nettype wire

// file: core/oac_defines.svh
`ifndef OAC_DEFINES_SVH
`define OAC_DEFINES_SVH

// Clock and serial memory timing
`define OAC_CORE_CLK_NS   5
`define OAC_SPI_SCK_NS    40
`define OAC_SPI_HALF_LAST 3'((`OAC_SPI_SCK_NS / (2 * `OAC_CORE_CLK_NS)) - 1)

// Serial RAM commands
`define OAC_CMD_READ      8'h03
`define OAC_CMD_WRITE     8'h02

// Status byte bit positions
`define OAC_FLAG_ZERO     0
`define OAC_FLAG_NEG      1
`define OAC_FLAG_CARRY    2
`define OAC_FLAG_ELSE     5

// Reset values and word stride
`define OAC_RESET_WORD    16'h0000
`define OAC_RESET_FLAGS   8'h00
`define OAC_WORD_STEP     16'h0002
`define OAC_ALIGN_MASK    16'hFFFE

// Opcodes
`define OAC_OP_NOP        8'h00
`define OAC_OP_HALT       8'h01
`define OAC_OP_TRAP       8'h02
`define OAC_OP_DROP       8'h03
`define OAC_OP_PUSH       8'h04
`define OAC_OP_POP        8'h05
`define OAC_OP_RET        8'h06
`define OAC_OP_NOT        8'h07
`define OAC_OP_OUTLO      8'h08
`define OAC_OP_OUTHI      8'h09
`define OAC_OP_SETPTR     8'h0A
`define OAC_OP_TEST       8'h0B
`define OAC_OP_BRIND      8'h0C
`define OAC_OP_CALLIND    8'h0D
`define OAC_OP_STATUS     8'h10
`define OAC_OP_LDIND      8'b0100_01??
`define OAC_OP_CALLW      8'h3E
`define OAC_OP_LDW        8'h3F
`define OAC_OP_SRC        8'b10??_????
`define OAC_OP_BRANCH     8'b1100_0???
`define OAC_OP_CALL       8'b1101_0???
`define OAC_OP_IF         8'hF0
`define OAC_ALU_STORE     5'b10010

`endif

// file: core/oac_pkg.sv
package oac_pkg;

	// Sequencer states, Gray coded along fetch, operand, execute, memory
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_FETCH = 3'h1,
		S_OPND  = 3'h3,
		S_EXEC  = 3'h2,
		S_PTR   = 3'h6,
		S_MEMRD = 3'h7,
		S_MEMWR = 3'h5
	} oacState_type;

	// Where a memory read result goes
	typedef enum logic [1:0] {
		DEST_ACC = 2'h0,
		DEST_PC  = 2'h1,
		DEST_ALU = 2'h2
	} oacDest_type;

	typedef struct packed {
		logic [15:0] acc;
		logic [7:0]  flags;
	} oacAlu_type;

	typedef struct packed {
		logic        write;
		logic [1:0]  nBytes;
		logic [15:0] addr;
		logic [15:0] wdata;
	} oacMemReq_type;

	typedef struct packed {
		logic csN;
		logic sck;
		logic mosi;
	} oacSpiOut_type;

	typedef struct packed {
		oacState_type  state;
		oacDest_type   dest;
		logic [15:0]   pc;
		logic [15:0]   sp;
		logic [15:0]   dp;
		logic [15:0]   acc;
		logic [7:0]    flags;
		logic [7:0]    op;
		logic [15:0]   opnd;
		logic          lohi;
		logic          halt;
		logic          trap;
		logic          recovering;
		logic          skip;
		logic [7:0]    dataOut;
		logic          stepS1;
		logic          stepS2;
		logic [7:0]    inS1;
		logic [7:0]    inS2;
		logic          misoS1;
		logic          misoS2;
		oacMemReq_type memReq;
		logic          spiAct;
		logic          memDone;
		logic          csActive;
		logic          sck;
		logic          mosi;
		logic [2:0]    divCnt;
		logic [2:0]    bitIdx;
		logic [2:0]    byteIdx;
		logic [7:0]    shift;
		logic [15:0]   rdata;
	} oacRegs_type;

endpackage

// file: dv/oac_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module oac_core_asserts (
	input wire logic                   core_clk,
	input wire logic                   resetn,
	input wire logic                   clkEn,
	input wire logic                   stepIn,
	input wire logic [7:0]             dataIn,
	input wire logic [7:0]             dataOut,
	input wire logic                   busy,
	input wire logic                   halt,
	input wire logic                   trap,
	input wire oac_pkg::oacSpiOut_type spiOut,
	input wire logic                   spiMiso
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// Serial clock high for four core cycles, then low
	sequence sckHighPhase;
		spiOut.sck [*4] ##1 !spiOut.sck;
	endsequence

	// Outputs rest while reset is applied
	a_reset_quiet: assert property (disable iff (1'b0)
		!resetn |-> !busy && !halt && !trap && dataOut == 8'h00 && spiOut.csN)
		else $error("outputs active during reset");
	// A step from idle starts an instruction
	a_step_starts: assert property (
		$rose(stepIn) && !busy && !halt |-> ##[1:6] busy)
		else $error("step did not start an instruction");
	// Busy never rises without a step
	a_busy_cause: assert property (
		$rose(busy) |-> $past(stepIn, 2) || $past(stepIn, 3) || $past(stepIn, 4))
		else $error("busy rose without step");
	a_halt_sticky: assert property (halt |=> halt)
		else $error("halt left without reset");
	a_halt_idle: assert property (halt && !busy |=> !busy)
		else $error("halted machine restarted");
	a_trap_recover: assert property ($fell(trap) |-> busy || $past(busy))
		else $error("trap cleared without a step");
	a_select_busy: assert property (!spiOut.csN |-> busy)
		else $error("memory selected while not busy");
	a_sck_framed: assert property (spiOut.sck |-> !spiOut.csN)
		else $error("serial clock outside selection");
	a_cs_gap: assert property ($rose(spiOut.csN) |=> spiOut.csN)
		else $error("deselect shorter than two cycles");
	a_sck_phase: assert property ($rose(spiOut.sck) |-> sckHighPhase)
		else $error("serial clock high phase wrong");
	a_mosi_hold: assert property (spiOut.sck |-> $stable(spiOut.mosi))
		else $error("serial data moved while clock high");
	// Output byte only moves while an instruction runs
	a_out_steady: assert property (
		!busy && !$past(busy) |-> $stable(dataOut))
		else $error("output byte changed while idle");
endmodule // oac_core_asserts

`default_nettype wire

// file: dv/oac_core_test.sv
`timescale 1ns/10ps
`default_nettype none

module oac_core_test;
	logic                   core_clk;
	logic                   resetn;
	logic                   clkEn;
	logic                   stepIn;
	logic [7:0]             dataIn;
	logic [7:0]             dataOut;
	logic                   busy;
	logic                   halt;
	logic                   trap;
	oac_pkg::oacSpiOut_type spiOut;
	logic                   miso;
	logic [31:0]            seed = 32'hEF88C7C1;
	logic [31:0]            rnd;
	logic [15:0]            expQ [$];
	int                     error_cnt = 0;
	int                     tests_run = 0;
	// Program: word load, outputs, invert, status, add, stack, sub, tests, traps
	logic [7:0] prog [39] = '{
		8'h3F, 8'h34, 8'h12, 8'h08, 8'h09, 8'h07, 8'h08, 8'h10, 8'h08, 8'h88,
		8'hFF, 8'h08, 8'h04, 8'h82, 8'h00, 8'h08, 8'h05, 8'h09, 8'h98, 8'h22,
		8'hF0, 8'h00, 8'h08, 8'h08, 8'h98, 8'hFF, 8'hF0, 8'h01, 8'h09, 8'h98,
		8'h01, 8'h10, 8'h08, 8'h02, 8'h08, 8'h02, 8'h02, 8'h00, 8'h00};
	// Halt, trap and output byte after each step
	logic [15:0] expv [26] = '{
		16'h0000, 16'h0034, 16'h0012, 16'h0012, 16'h00CB,
		16'h00CB, 16'h0022, 16'h0022, 16'h0021, 16'h0021,
		16'h0021, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
		16'h0001, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
		16'h00FF, 16'h0026, 16'h0126, 16'h0026, 16'h0126,
		16'h0326};

	oac_core dut (
		.core_clk (core_clk),
		.resetn   (resetn),
		.clkEn    (clkEn),
		.stepIn   (stepIn),
		.dataIn   (dataIn),
		.dataOut  (dataOut),
		.busy     (busy),
		.halt     (halt),
		.trap     (trap),
		.spiOut   (spiOut),
		.spiMiso  (miso)
	);

	oac_spi_ram ram (
		.csN  (spiOut.csN),
		.sck  (spiOut.sck),
		.mosi (spiOut.mosi),
		.miso (miso)
	);

	// Core clock, 5 ns period
	always #2.5 core_clk = ~core_clk;

	function automatic logic [31:0] xs(inout logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Eight-cycle reset, outputs checked while it is applied
	task automatic rst_pulse();
		resetn <= 1'b0;
		repeat (8) @(posedge core_clk);
		check({2'b00, dataOut, busy, halt, trap, spiOut}, 16'h0004);
		resetn <= 1'b1;
		repeat (10) @(posedge core_clk);
	endtask

	// One-cycle step pulse, then wait for the instruction to finish
	task automatic step1(input logic [15:0] e);
		int n;
		n = 0;
		expQ.push_back(e);
		stepIn <= 1'b1;
		@(posedge core_clk);
		stepIn <= 1'b0;
		while (busy !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		if (busy !== 1'b1)
			error_cnt++;
		while (busy !== 1'b0 && n < 8000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 8000) begin
			error_cnt++;
			stop_test();
		end
		repeat (4) @(posedge core_clk);
	endtask

	// Busy must stay low for thirty cycles
	task automatic idle_chk();
		int bad;
		bad = 0;
		repeat (30) begin
			@(posedge core_clk);
			if (busy !== 1'b0)
				bad++;
		end
		check(16'(bad), 16'h0000);
	endtask

	// Each finished instruction is matched with the oldest expectation
	always begin
		@(negedge busy);
		repeat (2) @(posedge core_clk);
		if (expQ.size() > 0)
			check({6'h00, halt, trap, dataOut}, expQ.pop_front());
	end

	// Main sequence: program run, fault, reset, held-step run to halt
	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		clkEn = 1'b1;
		stepIn = 1'b0;
		dataIn = 8'h00;
		for (int i = 0; i < 39; i++)
			ram.mem[i] = prog[i];
		rst_pulse();
		rnd = xs(seed);
		dataIn <= rnd[7:0];
		expv[11] = {8'h00, rnd[7:0]};
		expv[12] = {8'h00, rnd[7:0]};
		for (int i = 0; i < 26; i++)
			step1(expv[i]);
		stepIn <= 1'b1;
		@(posedge core_clk);
		stepIn <= 1'b0;
		idle_chk();
		check({14'h0000, halt, trap}, 16'h0003);
		ram.mem[0] = 8'h00;
		ram.mem[1] = 8'h01;
		rst_pulse();
		expQ.push_back(16'h0000);
		expQ.push_back(16'h0200);
		stepIn <= 1'b1;
		for (int k = 0; k < 4000 && halt !== 1'b1; k++)
			@(posedge core_clk);
		check({15'h0000, halt}, 16'h0001);
		idle_chk();
		stepIn <= 1'b0;
		check(16'(expQ.size()), 16'h0000);
		stop_test();
	end
endmodule // oac_core_test

bind oac_core oac_core_asserts chk (
	.core_clk (core_clk),
	.resetn   (resetn),
	.clkEn    (clkEn),
	.stepIn   (stepIn),
	.dataIn   (dataIn),
	.dataOut  (dataOut),
	.busy     (busy),
	.halt     (halt),
	.trap     (trap),
	.spiOut   (spiOut),
	.spiMiso  (spiMiso)
);

`default_nettype wire

// file: dv/oac_spi_ram.sv
`timescale 1ns/10ps
`default_nettype none

module oac_spi_ram (
	input  wire logic csN,
	input  wire logic sck,
	input  wire logic mosi,
	output var  logic miso
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  sh;
	logic [7:0]  cmd;
	logic [7:0]  outB;
	logic [15:0] addr;
	int          bitCnt;

	initial miso = 1'b0;

	// Each selection starts a fresh frame
	always @(negedge csN) bitCnt = 0;

	// Command, address high and low, then write bytes, MSB first
	always @(posedge sck) if (!csN) begin
		sh = {sh[6:0], mosi};
		bitCnt++;
		if (bitCnt == 8) cmd = sh;
		else if (bitCnt == 16) addr[15:8] = sh;
		else if (bitCnt == 24) addr[7:0] = sh;
		else if (bitCnt > 24 && bitCnt % 8 == 0 && cmd == 8'h02) begin
			mem[addr] = sh;
			addr = addr + 16'h0001;
		end
	end

	// Read bytes stream out on falling clock, MSB first
	always @(negedge sck) if (!csN && cmd == 8'h03 && bitCnt >= 24) begin
		if (bitCnt % 8 == 0) begin
			outB = mem[addr];
			addr = addr + 16'h0001;
		end else
			outB = {outB[6:0], ~outB[7]};
		miso <= outB[7];
	end

	// Released line has no pull: show the inverse of the last bit
	always @(posedge csN) miso <= ~miso;
endmodule // oac_spi_ram

`default_nettype wire
